//--- logic/ofo_pkg.sv
package ofo_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SEL = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_APP = 8'h0C;
    localparam logic [7:0] ADDR_FBVAL = 8'h10;
    localparam logic [7:0] ADDR_OUT = 8'h14;
    localparam logic [7:0] ADDR_FORCED = 8'h18;
    localparam logic [7:0] ADDR_TRIP = 8'h1C;
    localparam logic [7:0] ADDR_GRPFB = 8'h20;
    localparam logic [7:0] ADDR_MODST = 8'h24;
    localparam logic [7:0] ADDR_IRQST = 8'h28;
    localparam logic [7:0] ADDR_IRQMSK = 8'h2C;
    // command codes written to the command register
    localparam logic [3:0] CMD_FORCE1 = 4'h1;
    localparam logic [3:0] CMD_FORCE0 = 4'h2;
    localparam logic [3:0] CMD_UNFORCE = 4'h3;
    localparam logic [3:0] CMD_GUNFORCE = 4'h4;
    localparam logic [3:0] CMD_SET = 4'h5;
    localparam logic [3:0] CMD_RESET = 4'h6;
    localparam logic [3:0] CMD_REACT = 4'h7;
    // command register fields
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_GRP_LSB = 8;
    // control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CONF_BIT = 1;
    // module status byte bit positions
    localparam int MST_FAIL_BIT = 0;
    localparam int MST_CHINOP_BIT = 1;
    localparam int MST_CONF_BIT = 5;
    localparam int MST_ABSENT_BIT = 6;
    // interrupt status bits
    localparam int IRQ_TRIP_BIT = 0;
    localparam int IRQ_FB_BIT = 1;
    localparam int IRQ_BADCMD_BIT = 2;
    localparam int IRQ_W = 3;
    localparam int GROUP_SIZE = 8;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

//--- logic/ofo_group_reduce.sv
`timescale 1ns/100ps
`default_nettype none
// per-group or-reduction of channel flags, registered
module ofo_group_reduce #(
    parameter int NCH = 16,
    parameter int GS = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // flags in, group flags out
    input wire logic [NCH-1:0] chanFlags,
    output logic [NCH/GS-1:0] grpFlags
);
    genvar g;
    generate
        for (g = 0; g < NCH/GS; g++) begin : gReduce
            // registered so the group flags are glitch free
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    grpFlags[g] <= 1'b0;
                end else begin
                    grpFlags[g] <= |chanFlags[g*GS +: GS];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- logic/ofo_top.sv
// Behaviour
// RL1: a forced channel keeps its forced level and ignores application writes until unforced.
// RL2: during fallback every affected output, forced ones too, takes the configured fallback value.
// RL3: force-to-1 and force-to-0 act on every channel selected in the select mask.
// RL4: unforce acts only on selected channels that are currently forced.
// RL5: global unforce frees all channels and is accepted only while some channel is forced.
// RL6: reset drives selected channels to 0 and set drives them to 1.
// RL7: a set or reset value is replaced by any later application write while running.
// RL8: reactivation re-enables a tripped output only when its terminal error is gone.
// RL9: reactivation names a group of eight channels and applies to the whole group together.
// RL10: reactivation leaves inactive channels and channels still in terminal error of the group unchanged.
// RL11: each output group in fallback raises its own group flag.
// RL12: module status byte shows failure in bit 0, inoperative channels in bit 1, config error in bit 5.
// RL13: output priority is fallback, then forced value, then latest set, reset or application value.
`timescale 1ns/100ps
`default_nettype none
module ofo_top #(
    parameter int NCH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // fault sources
    input wire logic [NCH-1:0] termError,
    input wire logic [NCH/8-1:0] groupFallback,
    input wire logic [NCH-1:0] chanActive,
    input wire logic moduleFault,
    input wire logic moduleAbsent,
    // outputs to drivers
    output logic [NCH-1:0] chanOut,
    output logic [NCH-1:0] chanEnable,
    output logic irq
);
    localparam int NG = NCH / ofo_pkg::GROUP_SIZE;

    // state machine of the ahb data phase
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WR = 3'b010,
        ST_RD = 3'b100
    } ofo_phase_e;

    ofo_phase_e phase_ff;
    ofo_phase_e nxt_phase;
    logic [7:0] addr_ff;
    logic [1:0] ctrl_ff;
    logic [NCH-1:0] sel_ff;
    logic [NCH-1:0] appVal_ff;
    logic [NCH-1:0] fbVal_ff;
    logic [NCH-1:0] forced_ff;
    logic [NCH-1:0] forceLvl_ff;
    logic [NCH-1:0] tripped_ff;
    logic [NCH-1:0] outVal_ff;
    logic [ofo_pkg::IRQ_W-1:0] irqSt_ff;
    logic [ofo_pkg::IRQ_W-1:0] irqMsk_ff;
    logic [NG-1:0] grpFb;
    logic [NG-1:0] grpFbPrev_ff;
    logic [NCH-1:0] fbChan;
    logic [NCH-1:0] nxt_out;
    logic [NCH-1:0] grpMask;
    logic [7:0] modStatus;
    logic [31:0] rdData;
    logic cmdWr;
    logic appWr;
    logic [3:0] cmdCode;
    logic [7:0] cmdGrp;
    logic badCmd;
    logic newTrip;
    logic [ofo_pkg::IRQ_W-1:0] irqClr;
    logic [ofo_pkg::IRQ_W-1:0] irqEvt;

    // decode of a byte offset against a register address
    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
        return a == reg_addr;
    endfunction

    // address phase accepted only on a nonseq/seq with hready
    always_comb begin
        nxt_phase = ST_IDLE;
        if (hsel && hready && htrans[1]) begin
            nxt_phase = hwrite ? ST_WR : ST_RD;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_ff <= ST_IDLE;
            addr_ff <= 8'h00;
        end else begin
            phase_ff <= nxt_phase;
            if (nxt_phase != ST_IDLE) begin
                addr_ff <= haddr[7:0];
            end
        end
    end

    // zero wait state slave, always okay; hsize is not decoded since
    // every register is one whole word and narrower accesses are not supported
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    assign cmdWr = (phase_ff == ST_WR) && hit(addr_ff, ofo_pkg::ADDR_CMD);
    assign appWr = (phase_ff == ST_WR) && hit(addr_ff, ofo_pkg::ADDR_APP);
    assign cmdCode = hwdata[ofo_pkg::CMD_CODE_LSB +: 4];
    assign cmdGrp = hwdata[ofo_pkg::CMD_GRP_LSB +: 8];

    // control, select, fallback value and mask registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff <= 2'h0;
            sel_ff <= '0;
            fbVal_ff <= '0;
            irqMsk_ff <= '0;
        end else if (phase_ff == ST_WR) begin
            if (hit(addr_ff, ofo_pkg::ADDR_CTRL)) ctrl_ff <= hwdata[1:0];
            if (hit(addr_ff, ofo_pkg::ADDR_SEL)) sel_ff <= hwdata[NCH-1:0];
            if (hit(addr_ff, ofo_pkg::ADDR_FBVAL)) fbVal_ff <= hwdata[NCH-1:0];
            if (hit(addr_ff, ofo_pkg::ADDR_IRQMSK)) irqMsk_ff <= hwdata[ofo_pkg::IRQ_W-1:0];
        end
    end

    // application value; set and reset overwrite it, so a later app write while running replaces them
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            appVal_ff <= '0;
        end else if (appWr && ctrl_ff[ofo_pkg::CTRL_RUN_BIT]) begin
            // RL7 app replaces set
            appVal_ff <= hwdata[NCH-1:0];
        end else if (cmdWr && cmdCode == ofo_pkg::CMD_SET) begin
            // RL6 set to one
            appVal_ff <= appVal_ff | sel_ff;
        end else if (cmdWr && cmdCode == ofo_pkg::CMD_RESET) begin
            // RL6 reset to zero
            appVal_ff <= appVal_ff & ~sel_ff;
        end
    end

    // forcing state per channel
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            forced_ff <= '0;
            forceLvl_ff <= '0;
        end else if (cmdWr) begin
            case (cmdCode)
                // RL3 force selected
                ofo_pkg::CMD_FORCE1: begin
                    forced_ff <= forced_ff | sel_ff;
                    forceLvl_ff <= forceLvl_ff | sel_ff;
                end
                ofo_pkg::CMD_FORCE0: begin
                    forced_ff <= forced_ff | sel_ff;
                    forceLvl_ff <= forceLvl_ff & ~sel_ff;
                end
                // RL4 only forced ones
                ofo_pkg::CMD_UNFORCE: begin
                    forced_ff <= forced_ff & ~(sel_ff & forced_ff);
                end
                // RL5 release all
                ofo_pkg::CMD_GUNFORCE: begin
                    if (|forced_ff) forced_ff <= '0;
                end
                default: begin
                    forced_ff <= forced_ff;
                end
            endcase
        end
    end

    // RL9 whole group mask
    always_comb begin
        grpMask = '0;
        for (int g = 0; g < NG; g++) begin
            if (cmdGrp == 8'(g)) grpMask[g*ofo_pkg::GROUP_SIZE +: ofo_pkg::GROUP_SIZE] = '1;
        end
    end

    // trip latch: a terminal error on an active channel trips it; reactivation clears
    // set wins over clear so an error still present keeps the channel tripped
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tripped_ff <= '0;
        end else begin
            // RL8 clear only if clean
            // RL10 skip inactive
            tripped_ff <= (tripped_ff & ~((cmdWr && cmdCode == ofo_pkg::CMD_REACT)
                                          ? (grpMask & chanActive & ~termError) : '0))
                          | (termError & chanActive);
        end
    end

    assign newTrip = |(termError & chanActive & ~tripped_ff);
    assign badCmd = cmdWr && ((cmdCode == ofo_pkg::CMD_GUNFORCE && !(|forced_ff))
                              || (cmdCode == ofo_pkg::CMD_REACT && cmdGrp >= 8'(NG))
                              || cmdCode == 4'h0 || cmdCode > ofo_pkg::CMD_REACT);

    // RL11 group fallback flags
    ofo_group_reduce #(
        .NCH(NCH),
        .GS(ofo_pkg::GROUP_SIZE)
    ) u_ofo_group_reduce (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .chanFlags(fbChan),
        .grpFlags(grpFb)
    );

    // expand fallback inputs to channels
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : gFb
            assign fbChan[c] = groupFallback[c / ofo_pkg::GROUP_SIZE];
        end
    endgenerate

    // RL13 output priority
    // RL2 fallback first
    // RL1 forced holds
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            if (fbChan[i]) nxt_out[i] = fbVal_ff[i];
            else if (forced_ff[i]) nxt_out[i] = forceLvl_ff[i];
            else nxt_out[i] = appVal_ff[i];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            outVal_ff <= '0;
        end else begin
            outVal_ff <= nxt_out;
        end
    end

    assign chanOut = outVal_ff;
    assign chanEnable = ~tripped_ff;

    // RL12 status byte
    always_comb begin
        modStatus = 8'h00;
        modStatus[ofo_pkg::MST_FAIL_BIT] = moduleFault;
        modStatus[ofo_pkg::MST_CHINOP_BIT] = |tripped_ff;
        modStatus[ofo_pkg::MST_CONF_BIT] = ctrl_ff[ofo_pkg::CTRL_CONF_BIT];
        modStatus[ofo_pkg::MST_ABSENT_BIT] = moduleAbsent;
    end

    // a read clears only the bits it returned, so an event that lands between the
    // address phase snapshot and the data phase edge is not lost; a new event wins
    assign irqClr = (phase_ff == ST_RD && hit(addr_ff, ofo_pkg::ADDR_IRQST)) ? hrdata[ofo_pkg::IRQ_W-1:0] : '0;
    assign irqEvt = {badCmd, |(grpFb & ~grpFbPrev_ff), newTrip};

    // sticky interrupt events
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqSt_ff <= '0;
            grpFbPrev_ff <= '0;
        end else begin
            grpFbPrev_ff <= grpFb;
            irqSt_ff <= (irqSt_ff & ~irqClr) | irqEvt;
        end
    end

    assign irq = |(irqSt_ff & irqMsk_ff);

    // read mux, unmapped offsets read zero
    always_comb begin
        rdData = ofo_pkg::RESET_WORD;
        case (haddr[7:0])
            ofo_pkg::ADDR_CTRL: rdData[1:0] = ctrl_ff;
            ofo_pkg::ADDR_SEL: rdData[NCH-1:0] = sel_ff;
            ofo_pkg::ADDR_APP: rdData[NCH-1:0] = appVal_ff;
            ofo_pkg::ADDR_FBVAL: rdData[NCH-1:0] = fbVal_ff;
            ofo_pkg::ADDR_OUT: rdData[NCH-1:0] = outVal_ff;
            ofo_pkg::ADDR_FORCED: rdData[NCH-1:0] = forced_ff;
            ofo_pkg::ADDR_TRIP: rdData[NCH-1:0] = tripped_ff;
            ofo_pkg::ADDR_GRPFB: rdData[NG-1:0] = grpFb;
            ofo_pkg::ADDR_MODST: rdData[7:0] = modStatus;
            ofo_pkg::ADDR_IRQST: rdData[ofo_pkg::IRQ_W-1:0] = irqSt_ff;
            ofo_pkg::ADDR_IRQMSK: rdData[ofo_pkg::IRQ_W-1:0] = irqMsk_ff;
            default: rdData = ofo_pkg::RESET_WORD;
        endcase
    end

    // read data registered at the address phase, stands in the data phase
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= '0;
        end else if (nxt_phase == ST_RD) begin
            hrdata <= rdData;
        end
    end
endmodule
`default_nettype wire

//--- verif/ofo_host_bfm.sv
`timescale 1ns/100ps
`default_nettype none
// rack processor side: issues application and debug accesses as single words
module ofo_host_bfm (
    // clock
    input wire logic sys_clk,
    // ahb-lite master side
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout
);
    // bus idle from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end
    // no wait count assumed: only the bench timeout ends a stalled transfer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : ~hwdata; // unused data lines toggle on reads
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
endmodule
`default_nettype wire

//--- verif/ofo_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ofo_top_chk #(
    parameter int NCH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // channels
    input wire logic [NCH-1:0] termError,
    input wire logic [NCH/8-1:0] groupFallback,
    input wire logic [NCH-1:0] chanActive,
    input wire logic [NCH-1:0] chanOut,
    input wire logic [NCH-1:0] chanEnable
);
    logic wrPhase_ff;
    logic [7:0] addr_ff;
    logic [NCH-1:0] fbVal_ff;
    logic [NCH-1:0] fbMask;
    // shadow of the fallback value register, so outputs can be judged without peeking inside
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPhase_ff <= 1'b0;
            addr_ff <= 8'h00;
            fbVal_ff <= '0;
        end else if (hready) begin
            wrPhase_ff <= hsel & htrans[1] & hwrite;
            addr_ff <= haddr[7:0];
            if (wrPhase_ff && addr_ff == ofo_pkg::ADDR_FBVAL) begin
                fbVal_ff <= hwdata[NCH-1:0];
            end
        end
    end
    // per-channel view of the group fallback inputs
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            fbMask[i] = groupFallback[i/8];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_fallback;
        ##1 ((chanOut ^ $past(fbVal_ff)) & $past(fbMask)) == '0;
    endproperty
    a_fallback: assert property (p_fallback) else $error("fallback value not applied");
    property p_trip;
        ##1 ($past(termError & chanActive) & chanEnable) == '0;
    endproperty
    a_trip: assert property (p_trip) else $error("active channel with error not tripped");
    property p_noRiseBad;
        ((chanEnable & ~$past(chanEnable)) & ($past(termError) | ~$past(chanActive))) == '0;
    endproperty
    a_noRiseBad: assert property (p_noRiseBad) else $error("reactivated with error or inactive");
    property p_riseNeedsCmd;
        (chanEnable & ~$past(chanEnable)) != '0 |-> $past(wrPhase_ff);
    endproperty
    a_riseNeedsCmd: assert property (p_riseNeedsCmd) else $error("output re-enabled without a command");
    property p_oneGroup;
        !((|(chanEnable[7:0] & ~$past(chanEnable[7:0]))) && (|(chanEnable[NCH-1:8] & ~$past(chanEnable[NCH-1:8]))));
    endproperty
    a_oneGroup: assert property (p_oneGroup) else $error("reactivation spans two groups");
    property p_noFall;
        ((~chanEnable & $past(chanEnable)) & ~$past(termError & chanActive)) == '0;
    endproperty
    a_noFall: assert property (p_noFall) else $error("healthy channel tripped");
    property p_outStable;
        $changed(chanOut) |-> $past(wrPhase_ff, 2) || ($past(groupFallback) != $past(groupFallback, 2));
    endproperty
    a_outStable: assert property (p_outStable) else $error("output changed without a cause");
    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("bus response not ready and okay");
    c_fallback: cover property (groupFallback != '0 ##1 groupFallback != '0);
    c_trip: cover property (chanEnable != '1);
    c_react: cover property ((chanEnable & ~$past(chanEnable)) != '0);
endmodule
bind ofo_top ofo_top_chk #(.NCH(NCH)) u_ofo_top_chk (.sys_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hreadyout, .hresp, .termError, .groupFallback, .chanActive, .chanOut, .chanEnable);
`default_nettype wire

//--- verif/output_force_override_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module output_force_override_control_tb;
    // clock, reset, design pins and bench model state
    logic sysClk = 1'b0;
    logic arstN = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, irq, moduleFault, moduleAbsent;
    logic [1:0] htrans, groupFallback;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rdv, sel, sel2, app, appV, fb, frc, f1, act, err, trip;
    logic [15:0] termError, chanActive, chanOut, chanEnable;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    // 25 MHz system clock
    always #20 sysClk = ~sysClk;
    ofo_top #(.NCH(16)) u_ofo_top (.sys_clk(sysClk), .arst_n(arstN), .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .termError, .groupFallback, .chanActive,
        .moduleFault, .moduleAbsent, .chanOut, .chanEnable, .irq);
    ofo_host_bfm u_ofo_host_bfm (.sys_clk(sysClk), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hrdata,
        .hreadyout);
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sysClk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic final_report();
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one idle edge after each write lets the registered outputs follow
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_ofo_host_bfm.xfer(1'b1, a, d, rdv);
        @(posedge sysClk);
    endtask
    task automatic cmd(input logic [3:0] c, input logic [7:0] g);
        wr(ofo_pkg::ADDR_CMD, {16'h0000, g, 4'h0, c});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        u_ofo_host_bfm.xfer(1'b0, a, 32'h0000_0000, rdv);
        cmp(nm, e, rdv);
    endtask
    // level output looked at mid-cycle, away from the edge
    task automatic chkIrq(input logic e);
        @(negedge sysClk);
        cmp("irq", {31'h0, e}, {31'h0, irq});
        @(posedge sysClk);
    endtask
    function automatic logic [31:0] outv();
        return (appV & ~frc) | (f1 & frc);
    endfunction
    initial begin
        {moduleFault, moduleAbsent, termError, groupFallback} = '0;
        chanActive = 16'hFFFF;
        repeat (5) @(posedge sysClk);
        arstN <= 1'b1;
        rdv = $urandom(14);
        @(posedge sysClk);
        rd(ofo_pkg::ADDR_OUT, 32'h0000_0000, "out after reset");
        rd(8'h3C, 32'h0000_0000, "unmapped");
        wr(ofo_pkg::ADDR_CTRL, 32'h0000_0001);
        {appV, frc, f1} = '0;
        repeat (4) begin
            sel = $urandom & 32'h0000_FFFF;
            sel2 = $urandom & 32'h0000_FFFF;
            app = $urandom & 32'h0000_FFFF;
            fb = $urandom & 32'h0000_FFFF;
            wr(ofo_pkg::ADDR_SEL, sel);
            cmd(ofo_pkg::CMD_SET, 8'h00);
            appV |= sel;
            rd(ofo_pkg::ADDR_OUT, outv(), "out set");
            cmd(ofo_pkg::CMD_RESET, 8'h00);
            appV &= ~sel;
            rd(ofo_pkg::ADDR_OUT, outv(), "out reset");
            wr(ofo_pkg::ADDR_APP, app);
            appV = app;
            rd(ofo_pkg::ADDR_OUT, outv(), "out app");
            cmd(ofo_pkg::CMD_FORCE1, 8'h00);
            frc |= sel;
            f1 |= sel;
            wr(ofo_pkg::ADDR_SEL, sel2);
            cmd(ofo_pkg::CMD_FORCE0, 8'h00);
            frc |= sel2;
            f1 &= ~sel2;
            wr(ofo_pkg::ADDR_APP, ~app & 32'h0000_FFFF);
            appV = ~app & 32'h0000_FFFF;
            rd(ofo_pkg::ADDR_OUT, outv(), "out forced");
            cmp("chanOut", outv(), {16'h0000, chanOut});
            rd(ofo_pkg::ADDR_FORCED, frc, "forced mask");
            sel2 = $urandom & 32'h0000_FFFF;
            wr(ofo_pkg::ADDR_SEL, sel2);
            cmd(ofo_pkg::CMD_UNFORCE, 8'h00);
            frc &= ~sel2;
            rd(ofo_pkg::ADDR_FORCED, frc, "unforce mask");
            rd(ofo_pkg::ADDR_OUT, outv(), "out unforce");
            wr(ofo_pkg::ADDR_FBVAL, fb);
            groupFallback <= 2'b01;
            repeat (2) @(posedge sysClk);
            rd(ofo_pkg::ADDR_OUT, (outv() & 32'h0000_FF00) | {24'h00_0000, fb[7:0]}, "out fallback");
            rd(ofo_pkg::ADDR_GRPFB, 32'h0000_0001, "group flag");
            rd(ofo_pkg::ADDR_IRQST, 32'h0000_0002, "irq fallback");
            groupFallback <= 2'b00;
            repeat (2) @(posedge sysClk);
            rd(ofo_pkg::ADDR_OUT, outv(), "out after fallback");
            cmd(ofo_pkg::CMD_GUNFORCE, 8'h00);
            frc = '0;
            rd(ofo_pkg::ADDR_OUT, outv(), "out global unforce");
            wr(ofo_pkg::ADDR_IRQMSK, 32'h0000_0000);
            cmd(ofo_pkg::CMD_GUNFORCE, 8'h00);
            chkIrq(1'b0);
            wr(ofo_pkg::ADDR_IRQMSK, 32'h0000_0007);
            chkIrq(1'b1);
            rd(ofo_pkg::ADDR_IRQST, 32'h0000_0004, "irq bad command");
            chkIrq(1'b0);
        end
        act = $urandom & 32'h0000_FFFF;
        err = $urandom & 32'h0000_FFFF;
        chanActive <= act[15:0];
        termError <= err[15:0];
        repeat (2) @(posedge sysClk);
        trip = act & err;
        rd(ofo_pkg::ADDR_TRIP, trip, "trip mask");
        cmp("enable", ~trip & 32'h0000_FFFF, {16'h0000, chanEnable});
        rd(ofo_pkg::ADDR_IRQST, {31'h0, |trip}, "irq trip");
        {moduleFault, moduleAbsent} <= 2'b11;
        wr(ofo_pkg::ADDR_CTRL, 32'h0000_0003);
        rd(ofo_pkg::ADDR_MODST, {25'h0, 1'b1, 1'b1, 3'h0, |trip, 1'b1}, "module status");
        err = err & $urandom;
        termError <= err[15:0];
        @(posedge sysClk);
        for (int g = 0; g < 2; g++) begin
            cmd(ofo_pkg::CMD_REACT, g[7:0]);
            trip &= ~(act & ~err & (32'h0000_00FF << (8 * g)));
            rd(ofo_pkg::ADDR_TRIP, trip, "trip after reactivation");
        end
        final_report();
    end
endmodule
`default_nettype wire
